// [design/wdtc_pkg.sv]
// Package for the watchdog timeout core: register map, fields, resets, types.
// Assumes a 32-bit APB register bus on a single peripheral clock.
package wdtc_pkg;
   localparam logic [11:0] OFS_RELOAD = 12'h000;
   localparam logic [11:0] OFS_COUNT = 12'h004;
   localparam logic [11:0] OFS_CTRL = 12'h008;
   localparam logic [11:0] OFS_CLEAR = 12'h00C;
   localparam logic [11:0] OFS_RAW = 12'h010;
   localparam logic [11:0] OFS_MASKED = 12'h014;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h020;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h024;
   localparam int CTRL_IRQ_EN_BIT = 0;
   localparam int CTRL_RST_EN_BIT = 1;
   localparam int RAW_FLAG_BIT = 0;
   localparam int EV_FIRST_BIT = 0;
   localparam int EV_SECOND_BIT = 1;
   localparam logic [31:0] RELOAD_RESET = 32'hFFFFFFFF;
   localparam logic [31:0] COUNT_RESET = 32'hFFFFFFFF;
   localparam logic [1:0] EV_RESET = 2'h0;
   localparam logic [31:0] CLEAR_READ_VAL = 32'h00000000;
   typedef struct packed {
      logic rst_en;
      logic irq_en;
   } wdtc_ctrl_t;
endpackage

// [design/wdtc_core.sv]
// Watchdog timeout core: 32-bit down counter, reload, interrupt and reset out.
// Assumes an APB master on pclk; outputs are registered.
// Summary of operation
// (RL1) A 32-bit reload register supplies the down counter start value.
// (RL2) Writing reload copies the value into the counter immediately.
// (RL3) Writing reload with zero raises the timeout interrupt at once.
// (RL4) Count readout returns the live counter value.
// (RL5) Control bit 1 enables reset output, bit 0 interrupt; both reset low.
// (RL6) After interrupt enable is set, control writes are ignored.
// (RL7) Only hardware reset clears the enable and unblocks control writes.
// (RL8) Any write to the clear register reloads and drops the interrupt, unless a first timeout falls in that cycle.
// (RL9) Clear register is write-only; reads return zero (CLEAR_READ_VAL).
// (RL10) Raw status bit 0 shows the unmasked timeout flag.
// (RL11) Counter reaching zero gives first timeout, reloads, keeps counting.
// (RL12) Second zero with flag pending and reset enabled asserts system reset.
// (RL13) Reload writes never clear a pending timeout.
// (RL14) Masked flag equals raw flag AND interrupt enable, drives interrupt.
// (RL15) Counter decrements each cycle while enabled, holds otherwise.
// (RL16) Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
module wdtc_core (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Watchdog outputs
   output logic timeout_irq,
   output logic sys_reset,
   output logic event_irq
);
   logic [31:0] reload_interval_r;
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   wdtc_pkg::wdtc_ctrl_t ctrl_r;
   logic raw_flag_r;
   logic raw_flag_nxt;
   logic sys_reset_r;
   logic [1:0] ev_stat_r;
   logic [1:0] ev_mask_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic timeout_irq_r;
   logic event_irq_r;
   logic pready_r;

   // Bus decode; the slave always answers in the access cycle, no waits
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire sel_reload = paddr == wdtc_pkg::OFS_RELOAD;
   wire sel_count = paddr == wdtc_pkg::OFS_COUNT;
   wire sel_ctrl = paddr == wdtc_pkg::OFS_CTRL;
   wire sel_clear = paddr == wdtc_pkg::OFS_CLEAR;
   wire sel_raw = paddr == wdtc_pkg::OFS_RAW;
   wire sel_masked = paddr == wdtc_pkg::OFS_MASKED;
   wire sel_istat = paddr == wdtc_pkg::OFS_IRQ_STAT;
   wire sel_imask = paddr == wdtc_pkg::OFS_IRQ_MASK;
   wire mapped = sel_reload | sel_count | sel_ctrl | sel_clear | sel_raw | sel_masked | sel_istat | sel_imask;
   wire full_word = pstrb == 4'hF;
   // Partial strobes on the reload word would leave a torn start value
   wire wr_reload = wr & sel_reload & full_word;
   wire wr_ctrl = wr & sel_ctrl & ~ctrl_r.irq_en; // see (RL6) (RL7)
   wire wr_clear = wr & sel_clear; // see (RL8)
   wire wr_istat = wr & sel_istat & pstrb[0];
   wire wr_imask = wr & sel_imask & pstrb[0];

   // Counter events
   wire at_zero = ctrl_r.irq_en & (count_r == 32'h00000000);
   wire first_to = at_zero & ~raw_flag_r; // see (RL11)
   wire second_to = at_zero & raw_flag_r & ctrl_r.rst_en; // see (RL12)
   wire zero_load = wr_reload & (pwdata == 32'h00000000);

   // Counter next value: bus loads win, zero reloads, else decrement
   always_comb begin
      count_nxt = count_r;
      if (wr_reload) begin
         count_nxt = pwdata; // see (RL2)
      end else if (wr_clear) begin
         count_nxt = reload_interval_r; // see (RL8)
      end else if (at_zero) begin
         count_nxt = reload_interval_r; // see (RL11)
      end else if (ctrl_r.irq_en) begin
         count_nxt = count_r - 32'h00000001; // see (RL15)
      end
   end

   // Flag: a timeout in the clear cycle still sets it; reload never clears
   always_comb begin
      raw_flag_nxt = raw_flag_r;
      if (wr_clear) begin
         raw_flag_nxt = 1'b0;
      end
      if (first_to | zero_load) begin
         raw_flag_nxt = 1'b1; // see (RL3) (RL13)
      end
   end

   wire masked_flag = raw_flag_r & ctrl_r.irq_en; // see (RL14)
   wire [1:0] ev_set = {second_to, first_to | zero_load};

   // Read mux; reserved bits are zero
   wire [31:0] rd_val =
      sel_reload ? reload_interval_r :
      sel_count ? count_r : // see (RL4)
      sel_ctrl ? {30'h00000000, ctrl_r.rst_en, ctrl_r.irq_en} : // see (RL16)
      sel_clear ? wdtc_pkg::CLEAR_READ_VAL : // see (RL9)
      sel_raw ? {31'h00000000, raw_flag_r} : // see (RL10)
      sel_masked ? {31'h00000000, masked_flag} :
      sel_istat ? {30'h00000000, ev_stat_r} :
      sel_imask ? {30'h00000000, ev_mask_r} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_interval_r <= wdtc_pkg::RELOAD_RESET;
         count_r <= wdtc_pkg::COUNT_RESET;
      end else begin
         if (wr_reload) begin
            reload_interval_r <= pwdata; // see (RL1)
         end
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '0; // see (RL5) (RL7)
         raw_flag_r <= 1'b0;
         sys_reset_r <= 1'b0;
      end else begin
         if (wr_ctrl & pstrb[0]) begin
            ctrl_r.rst_en <= pwdata[wdtc_pkg::CTRL_RST_EN_BIT]; // see (RL5)
            ctrl_r.irq_en <= pwdata[wdtc_pkg::CTRL_IRQ_EN_BIT];
         end
         raw_flag_r <= raw_flag_nxt;
         // System reset holds until hardware reset
         if (second_to) begin
            sys_reset_r <= 1'b1; // see (RL12)
         end
      end
   end

   // Sticky event status, write one to clear; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_stat_r <= wdtc_pkg::EV_RESET;
         ev_mask_r <= wdtc_pkg::EV_RESET;
      end else begin
         ev_stat_r <= (ev_stat_r & ~(wr_istat ? pwdata[1:0] : 2'h0)) | ev_set;
         if (wr_imask) begin
            ev_mask_r <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
         timeout_irq_r <= 1'b0;
         event_irq_r <= 1'b0;
         // Zero wait states, still a flop so every output is registered
         pready_r <= 1'b1;
      end else begin
         pready_r <= 1'b1;
         prdata_r <= (psel & ~penable & ~pwrite) ? rd_val : prdata_r;
         pslverr_r <= psel & ~penable & ~mapped;
         timeout_irq_r <= raw_flag_nxt & (wr_ctrl & pstrb[0] ? pwdata[0] : ctrl_r.irq_en); // see (RL14)
         event_irq_r <= |(((ev_stat_r & ~(wr_istat ? pwdata[1:0] : 2'h0)) | ev_set)
                        & (wr_imask ? pwdata[1:0] : ev_mask_r));
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign timeout_irq = timeout_irq_r;
   assign sys_reset = sys_reset_r;
   assign event_irq = event_irq_r;

   // Bus answer and read path
   a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
      pready)
      else $error("pready dropped");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && mapped |=> !pslverr)
      else $error("mapped access flagged error");
   a_err_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |=> !pslverr)
      else $error("error response too long");
   a_read_capture: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite |=> prdata == $past(rd_val))
      else $error("read data not captured");
   a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
   a_count_read: assert property (@(posedge pclk) disable iff (!presetn) // see (RL4)
      psel && !penable && !pwrite && sel_count |=> prdata == $past(count_r))
      else $error("count readout wrong");
   a_raw_read: assert property (@(posedge pclk) disable iff (!presetn) // see (RL10)
      psel && !penable && !pwrite && sel_raw |=> prdata == {31'h00000000, $past(raw_flag_r)})
      else $error("raw status read wrong");
   a_masked_read: assert property (@(posedge pclk) disable iff (!presetn) // see (RL14)
      psel && !penable && !pwrite && sel_masked |=> prdata == {31'h00000000, $past(masked_flag)})
      else $error("masked status read wrong");
   a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn) // see (RL16)
      psel && !penable && !pwrite && !mapped |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_clear_read: assert property (@(posedge pclk) disable iff (!presetn) // see (RL9)
      psel && !penable && !pwrite && sel_clear |=> prdata == wdtc_pkg::CLEAR_READ_VAL)
      else $error("clear register read wrong");
   a_ctrl_reserved: assert property (@(posedge pclk) disable iff (!presetn) // see (RL16)
      psel && !penable && !pwrite && sel_ctrl |=> prdata[31:2] == 30'h00000000)
      else $error("control reserved bits set");

   // Reload and counter
   a_reload_store: assert property (@(posedge pclk) disable iff (!presetn) // see (RL1)
      wr_reload |=> reload_interval_r == $past(pwdata))
      else $error("reload not stored");
   a_reload_stable: assert property (@(posedge pclk) disable iff (!presetn) // see (RL1)
      !wr_reload |=> $stable(reload_interval_r))
      else $error("reload moved");
   a_reload_copy: assert property (@(posedge pclk) disable iff (!presetn) // see (RL2)
      wr_reload |=> count_r == $past(pwdata))
      else $error("reload not copied");
   a_zero_load_irq: assert property (@(posedge pclk) disable iff (!presetn) // see (RL3)
      zero_load |=> raw_flag_r)
      else $error("zero reload did not raise flag");
   a_first_timeout: assert property (@(posedge pclk) disable iff (!presetn) // see (RL11)
      first_to && !wr_reload |=> raw_flag_r && count_r == $past(reload_interval_r))
      else $error("first timeout wrong");
   a_zero_reload: assert property (@(posedge pclk) disable iff (!presetn) // see (RL11)
      at_zero && !wr_reload && !wr_clear |=> count_r == $past(reload_interval_r))
      else $error("zero did not reload");
   a_clear_reload: assert property (@(posedge pclk) disable iff (!presetn) // see (RL8)
      wr_clear && !wr_reload && !at_zero |=> !raw_flag_r && count_r == reload_interval_r)
      else $error("clear failed");
   a_count_dec: assert property (@(posedge pclk) disable iff (!presetn) // see (RL15)
      ctrl_r.irq_en && count_r != 0 && !wr_reload && !wr_clear |=> count_r == $past(count_r) - 1)
      else $error("count not decremented");
   a_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // see (RL15)
      !ctrl_r.irq_en && !wr_reload && !wr_clear |=> $stable(count_r))
      else $error("count moved");

   // Control lock
   a_ctrl_locked: assert property (@(posedge pclk) disable iff (!presetn) // see (RL6)
      ctrl_r.irq_en |=> ctrl_r.irq_en && $stable(ctrl_r))
      else $error("locked control changed");
   a_ctrl_irq_write: assert property (@(posedge pclk) disable iff (!presetn) // see (RL5)
      wr_ctrl && pstrb[0] |=> ctrl_r.irq_en == $past(pwdata[wdtc_pkg::CTRL_IRQ_EN_BIT]))
      else $error("interrupt enable not written");
   a_ctrl_rst_write: assert property (@(posedge pclk) disable iff (!presetn) // see (RL5)
      wr_ctrl && pstrb[0] |=> ctrl_r.rst_en == $past(pwdata[wdtc_pkg::CTRL_RST_EN_BIT]))
      else $error("reset enable not written");
   a_ctrl_no_strobe: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_ctrl && !pstrb[0] |=> $stable(ctrl_r))
      else $error("control written without strobe");

   // Flags and outputs
   a_flag_clear_only: assert property (@(posedge pclk) disable iff (!presetn) // see (RL13)
      raw_flag_r && !wr_clear |=> raw_flag_r)
      else $error("flag dropped without clear");
   a_reload_keeps: assert property (@(posedge pclk) disable iff (!presetn) // see (RL13)
      raw_flag_r && wr_reload && !wr_clear |=> raw_flag_r)
      else $error("reload cleared flag");
   a_flag_set_cause: assert property (@(posedge pclk) disable iff (!presetn) // see (RL11)
      !raw_flag_r && !first_to && !zero_load |=> !raw_flag_r)
      else $error("flag set without timeout");
   a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn) // see (RL8)
      wr_clear && first_to |=> raw_flag_r)
      else $error("clear beat timeout");
   a_masked_irq: assert property (@(posedge pclk) disable iff (!presetn) // see (RL14)
      ##1 timeout_irq == masked_flag)
      else $error("irq not masked flag");
   a_irq_off_disabled: assert property (@(posedge pclk) disable iff (!presetn) // see (RL14)
      !ctrl_r.irq_en |-> !timeout_irq)
      else $error("irq while disabled");
   a_second_reset: assert property (@(posedge pclk) disable iff (!presetn) // see (RL12)
      second_to |=> sys_reset_r)
      else $error("second timeout no reset");
   a_reset_sticky: assert property (@(posedge pclk) disable iff (!presetn) // see (RL12)
      sys_reset |=> sys_reset)
      else $error("system reset dropped");
   a_reset_cause: assert property (@(posedge pclk) disable iff (!presetn) // see (RL12)
      $rose(sys_reset) |-> $past(second_to))
      else $error("system reset without second timeout");
   a_no_reset_disabled: assert property (@(posedge pclk) disable iff (!presetn) // see (RL12)
      at_zero && raw_flag_r && !ctrl_r.rst_en && !sys_reset |=> !sys_reset)
      else $error("reset while reset output disabled");

   // Event status
   a_ev_first: assert property (@(posedge pclk) disable iff (!presetn)
      first_to |=> ev_stat_r[wdtc_pkg::EV_FIRST_BIT])
      else $error("first event not recorded");
   a_ev_second: assert property (@(posedge pclk) disable iff (!presetn)
      second_to |=> ev_stat_r[wdtc_pkg::EV_SECOND_BIT])
      else $error("second event not recorded");
   a_ev_w1c: assert property (@(posedge pclk) disable iff (!presetn)
      wr_istat && !(|ev_set) |=> ev_stat_r == ($past(ev_stat_r) & ~$past(pwdata[1:0])))
      else $error("event clear wrong");
   a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_imask |=> ev_mask_r == $past(pwdata[1:0]))
      else $error("event mask not written");
   a_ev_irq_match: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 event_irq == |(ev_stat_r & ev_mask_r))
      else $error("event irq mismatch");
endmodule

// [verification/watchdog_timeout_core_test.sv]
// Self-checking bench for the watchdog timeout core, driven over APB.
// Assumes zero wait states are legal but waits on pready anyway.
`timescale 1ns/1ps
module watchdog_timeout_core_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, timeout_irq, sys_reset, event_irq;
   int n_mismatch = 0, tests_run = 0;
   always #5 pclk = ~pclk;
   wdtc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timeout_irq(timeout_irq), .sys_reset(sys_reset), .event_irq(event_irq));
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
      if (pready !== 1'b1) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      bus(0, a, '0);
      chk(rd, e);
   endtask
   task automatic stop_test;
      $display("%0d compared, %0d wrong", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      rchk(wdtc_pkg::OFS_RELOAD, 32'hFFFFFFFF);
      rchk(wdtc_pkg::OFS_COUNT, 32'hFFFFFFFF);
      rchk(wdtc_pkg::OFS_CTRL, 32'h00000000);
      rchk(wdtc_pkg::OFS_RAW, 32'h00000000);
      chk({31'h0, err}, 32'h0);
      bus(1, wdtc_pkg::OFS_RELOAD, 32'h00000040);
      rchk(wdtc_pkg::OFS_COUNT, 32'h00000040);
      bus(1, wdtc_pkg::OFS_CTRL, 32'hFFFFFFFF);
      rchk(wdtc_pkg::OFS_CTRL, 32'h00000003);
      bus(1, wdtc_pkg::OFS_CTRL, 32'h00000000);
      rchk(wdtc_pkg::OFS_CTRL, 32'h00000003);
      bus(0, wdtc_pkg::OFS_COUNT, '0);
      chk({31'h0, rd < 32'h00000040}, 32'h1);
      $display("test setup done");
      for (int i = 0; i < 100 && timeout_irq !== 1'b1; i++) @(posedge pclk);
      chk({31'h0, timeout_irq}, 32'h1);
      bus(0, wdtc_pkg::OFS_COUNT, '0);
      chk({31'h0, rd > 32'h00000020}, 32'h1);
      rchk(wdtc_pkg::OFS_MASKED, 32'h00000001);
      bus(1, wdtc_pkg::OFS_RELOAD, 32'h00000100);
      rchk(wdtc_pkg::OFS_RAW, 32'h00000001);
      chk({31'h0, sys_reset}, 32'h0);
      // Event status, masked then unmasked, then W1C
      rchk(wdtc_pkg::OFS_IRQ_STAT, 32'h00000001);
      chk({31'h0, event_irq}, 32'h0);
      bus(1, wdtc_pkg::OFS_IRQ_MASK, 32'h00000001);
      @(posedge pclk);
      chk({31'h0, event_irq}, 32'h1);
      bus(1, wdtc_pkg::OFS_IRQ_STAT, 32'h00000001);
      rchk(wdtc_pkg::OFS_IRQ_STAT, 32'h00000000);
      chk({31'h0, event_irq}, 32'h0);
      bus(1, wdtc_pkg::OFS_CLEAR, 32'hA5A5A5A5);
      bus(0, wdtc_pkg::OFS_COUNT, '0);
      chk({31'h0, rd > 32'h000000F8}, 32'h1);
      rchk(wdtc_pkg::OFS_RAW, 32'h00000000);
      chk({31'h0, timeout_irq}, 32'h0);
      bus(0, wdtc_pkg::OFS_CLEAR, '0);
      bus(0, 12'h030, '0);
      chk(rd, 32'h00000000);
      chk({31'h0, err}, 32'h1);
      $display("test timeout done");
      bus(1, wdtc_pkg::OFS_RELOAD, 32'h00000000);
      @(posedge pclk);
      chk({31'h0, timeout_irq}, 32'h1);
      for (int i = 0; i < 10 && sys_reset !== 1'b1; i++) @(posedge pclk);
      chk({31'h0, sys_reset}, 32'h1);
      rchk(wdtc_pkg::OFS_IRQ_STAT, 32'h00000003);
      chk({31'h0, event_irq}, 32'h1);
      $display("test second timeout done");
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      chk({31'h0, sys_reset}, 32'h0);
      rchk(wdtc_pkg::OFS_CTRL, 32'h00000000);
      bus(1, wdtc_pkg::OFS_CTRL, 32'h00000002);
      rchk(wdtc_pkg::OFS_CTRL, 32'h00000002);
      pstrb <= 4'h1;
      bus(1, wdtc_pkg::OFS_RELOAD, 32'h12345678);
      pstrb <= 4'hF;
      rchk(wdtc_pkg::OFS_RELOAD, 32'hFFFFFFFF);
      $display("test hardware reset done");
      stop_test;
   end
endmodule
